// [verilog/fpp_ctrl.v]
// Purpose: Flash program and erase sequencer with block write protection.
// Assumes: Control bits arrive as plain ports from the CPU on sys_clk.
// Notes: Raw pins (test voltage detect, wait, stop) are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.vh"
module fpp_ctrl #(
   parameter AW = 16,
   parameter BW = 8
) (
   // Clock and reset.
   input wire sys_clk,
   input wire rst_n,
   // CPU control bits.
   input wire program_select_bit,
   input wire erase_select_bit,
   input wire mass_erase_bit,
   input wire high_voltage_enable_req,
   input wire [AW-1:0] target_addr,
   // Protect register update, taken only under test voltage.
   input wire block_protect_wr,
   input wire [BW-1:0] block_protect_wdata,
   // Pins and low-power entry.
   input wire elevated_test_voltage,
   input wire wait_mode,
   input wire stop_mode,
   // Array control and status.
   output reg array_program_r,
   output reg array_erase_r,
   output reg array_mass_r,
   output reg high_voltage_enable_r,
   output reg array_read_ok_r,
   output reg standby_r,
   output reg hv_refused_r,
   output reg [BW-1:0] block_protect_reg_r,
   output reg test_voltage_r
);
   // Raw pins that pass the two-stage synchroniser, one lane each.
   localparam NSYNC = `FPP_SYNC_N;

   // Sequencer states.
   localparam [1:0] ST_READ = `FPP_ST_READ;
   localparam [1:0] ST_ARMED = `FPP_ST_ARMED;
   localparam [1:0] ST_HV = `FPP_ST_HV;
   localparam [1:0] ST_RECOVER = `FPP_ST_RECOVER;

   // Sequencer state and read recovery counter.
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [7:0] rcv_cnt_r;
   reg [7:0] rcv_cnt_nxt;

   // Synchronised pins.
   wire [NSYNC-1:0] pin_raw;
   wire [NSYNC-1:0] pin_sync;
   wire tv_sync;
   wire lowpwr;

   // Protection decode.
   wire [AW-1:0] bp_ext;
   wire [AW-1:0] prot_start;
   wire bp_locked;
   wire all_prot;
   wire range_hit;
   wire mass_hit;
   wire protected_hit;
   wire bp_take;

   // Sequence decode.
   wire any_op;
   wire op_live;
   wire hv_live;
   wire abort;
   wire enter_rcv;
   wire hv_refuse;

   genvar gi;

   assign pin_raw = {stop_mode, wait_mode, elevated_test_voltage};

   // Each lane is a plain two flip-flop synchroniser. Only the second
   // stage is read, so a metastable first stage never reaches the logic.
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         reg s1_r;
         reg s2_r;
         always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end else begin
               s1_r <= pin_raw[gi];
               s2_r <= s1_r;
            end
         end
         assign pin_sync[gi] = s2_r;
      end
   endgenerate

   assign tv_sync = pin_sync[`FPP_SYNC_TV];
   // Wait and stop abort an operation in exactly the same way.
   assign lowpwr = pin_sync[`FPP_SYNC_WT] | pin_sync[`FPP_SYNC_SP];

   // The protected range starts at a base set by the register and runs
   // up to the top address; all ones in the register protects nothing.
   assign bp_ext = {{(AW-BW){1'b0}}, block_protect_reg_r};
   assign prot_start = `FPP_BP_BASE_MSB | (bp_ext << `FPP_BP_SHIFT);
   assign bp_locked = (block_protect_reg_r != `FPP_BP_UNPROT);
   assign all_prot = (block_protect_reg_r == `FPP_BP_ALLPROT);
   assign range_hit = bp_locked && (target_addr >= prot_start);
   assign mass_hit = mass_erase_bit && bp_locked;
   assign protected_hit = all_prot | range_hit | mass_hit;
   // A protect write without the test voltage is dropped silently.
   assign bp_take = block_protect_wr && tv_sync;

   // Either select arms the sequencer.
   assign any_op = program_select_bit | erase_select_bit;
   assign op_live = (state_nxt == ST_ARMED) || (state_nxt == ST_HV);
   assign hv_live = (state_nxt == ST_HV);
   assign abort = lowpwr && (state_r != ST_READ);
   // Recovery starts once, on the edge that enters it.
   assign enter_rcv = (state_nxt == ST_RECOVER) &&
      (state_r != ST_RECOVER);
   // Refusal only counts while armed, never during an abort.
   assign hv_refuse = (state_r == ST_ARMED) && high_voltage_enable_req &&
      protected_hit && !lowpwr;

   // Next state. The arm is dropped when both selects fall or the core
   // enters low power before high voltage is granted.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_READ: begin
            // Low power while reading needs no action.
            if (any_op && !lowpwr)
               state_nxt = ST_ARMED;
         end
         ST_ARMED: begin
            // Protection is judged against the live target address.
            if (lowpwr || !any_op)
               state_nxt = ST_READ;
            else if (high_voltage_enable_req && !protected_hit)
               state_nxt = ST_HV;
         end
         ST_HV: begin
            // Only the request or low power ends the high voltage phase.
            if (lowpwr)
               state_nxt = ST_RECOVER;
            else if (!high_voltage_enable_req)
               state_nxt = ST_RECOVER;
         end
         ST_RECOVER: begin
            // The counter was loaded on the way in.
            if (rcv_cnt_r == 8'h00)
               state_nxt = ST_READ;
         end
         default: state_nxt = ST_READ;
      endcase
   end

   // Recovery counter: loaded on entry to recovery, then counts to zero.
   always @* begin
      rcv_cnt_nxt = rcv_cnt_r;
      if (enter_rcv)
         rcv_cnt_nxt = `FPP_RCV_LOAD;
      else if (rcv_cnt_r != 8'h00)
         rcv_cnt_nxt = rcv_cnt_r - 8'h01;
   end

   // State register.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_READ;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The counter only runs in recovery; it rests at zero otherwise.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rcv_cnt_r <= 8'h00;
      end else begin
         rcv_cnt_r <= rcv_cnt_nxt;
      end
   end

   // High voltage follows the state, so it is only granted at a target that is
   // unprotected on entry; a later address or protect change does not drop it.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_voltage_enable_r <= 1'b0;
      end else begin
         high_voltage_enable_r <= hv_live;
      end
   end

   // Refusal is flagged on every armed cycle without low power that the request is
   // held against protection.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hv_refused_r <= 1'b0;
      end else begin
         hv_refused_r <= hv_refuse;
      end
   end

   // An abort drops every array control, which is the standby state.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         array_program_r <= 1'b0;
      end else if (abort) begin
         array_program_r <= 1'b0;
      end else begin
         array_program_r <= program_select_bit && op_live;
      end
   end

   // Erase select drives the array the same way as program select.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         array_erase_r <= 1'b0;
      end else if (abort) begin
         array_erase_r <= 1'b0;
      end else begin
         array_erase_r <= erase_select_bit && op_live;
      end
   end

   // Mass erase reaches the array only during high voltage and only
   // while no block is locked, so a locked part can never be wiped.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         array_mass_r <= 1'b0;
      end else if (abort) begin
         array_mass_r <= 1'b0;
      end else begin
         array_mass_r <= erase_select_bit && mass_erase_bit &&
            !bp_locked && hv_live;
      end
   end

   // Standby holds until software has dropped both selects.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         standby_r <= 1'b0;
      end else if (abort) begin
         standby_r <= 1'b1;
      end else if (!any_op) begin
         standby_r <= 1'b0;
      end
   end

   // After high voltage, reading resumes only once recovery has run out, so an
   // abort during high voltage pays the same recovery as a normal end of it.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         array_read_ok_r <= 1'b1;
      end else begin
         array_read_ok_r <= (state_nxt == ST_READ);
      end
   end

   // The protect register keeps its value through aborts; reset, or an all-ones
   // write under test voltage, returns it to fully unprotected.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         block_protect_reg_r <= `FPP_BP_UNPROT;
      end else if (bp_take) begin
         block_protect_reg_r <= block_protect_wdata;
      end
   end

   // Registered copy of the test voltage for software to read.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         test_voltage_r <= 1'b0;
      end else begin
         test_voltage_r <= tv_sync;
      end
   end
endmodule
`default_nettype wire

// [verilog/fpp_map.vh]
// Purpose: Constants for the flash program and protect controller.
// Assumes: 40 MHz system clock, 16-bit flash addresses.
// Notes: Times are in nanoseconds; cycle counts derive from them.
`ifndef FPP_MAP_VH
`define FPP_MAP_VH
`define FPP_CLK_PERIOD_NS 25
`define FPP_RCV_TIME_NS 1000
`define FPP_RCV_CYCLES ((`FPP_RCV_TIME_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
// Recovery counter load: one less than the 40 cycle recovery count.
`define FPP_RCV_LOAD 8'h27
// Synchroniser lanes for the raw pins.
`define FPP_SYNC_N 3
`define FPP_SYNC_TV 0
`define FPP_SYNC_WT 1
`define FPP_SYNC_SP 2
`define FPP_BP_UNPROT 8'hff
`define FPP_BP_ALLPROT 8'h00
`define FPP_BP_SHIFT 6
`define FPP_BP_BASE_MSB 16'h8000
`define FPP_ADDR_TOP 16'hffff
`define FPP_ST_READ 2'h0
`define FPP_ST_ARMED 2'h1
`define FPP_ST_HV 2'h2
`define FPP_ST_RECOVER 2'h3
`endif

// [tb/fpp_ctrl_sva.sv]
// Purpose: Checker for the flash program and protect controller.
// Assumes: Default widths, 40 cycles of read recovery.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_sva (
   // Clock, reset and controls.
   input wire logic sys_clk, rst_n, program_select_bit,
   input wire logic high_voltage_enable_req, wait_mode, stop_mode,
   input wire logic block_protect_wr, test_voltage_r,
   input wire logic [15:0] target_addr,
   // Array side.
   input wire logic array_program_r, array_erase_r, array_mass_r,
   input wire logic high_voltage_enable_r, array_read_ok_r, standby_r,
   input wire logic [7:0] block_protect_reg_r
);
   wire hv = high_voltage_enable_r;
   wire [7:0] bp = block_protect_reg_r;
   wire ok_addr = bp == 8'hff || target_addr < {2'b10, bp, 6'h00};
   wire wr_ok = block_protect_wr && test_voltage_r;
   wire go = program_select_bit && high_voltage_enable_req && bp == 8'hff
      && !wait_mode && !stop_mode;
   // Cycles since high voltage was last on; zero once the array reads.
   localparam int RCV_MIN = 40;
   logic [7:0] since_hv;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) since_hv <= 8'h00;
      else if (hv) since_hv <= 8'h01;
      else if (array_read_ok_r) since_hv <= 8'h00;
      else if (since_hv != 8'h00 && since_hv != 8'hff)
         since_hv <= since_hv + 8'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_arm;
      $rose(program_select_bit) ##1 go [*2];
   endsequence
   property p_on; s_arm |-> hv; endproperty
   property p_rcv; $fell(hv) |-> !array_read_ok_r [*8] ##[1:45] array_read_ok_r;
   endproperty
   property p_all; hv |-> bp != 8'h00; endproperty
   property p_rng; $rose(hv) |-> $past(ok_addr); endproperty
   property p_mass; array_mass_r |-> bp == 8'hff; endproperty
   property p_lock; bp != $past(bp) |-> $past(wr_ok); endproperty
   property p_abt; hv && (wait_mode || stop_mode) |-> ##[1:4] (standby_r && !hv);
   endproperty
   property p_sby; standby_r |-> !(array_program_r || array_erase_r || hv);
   endproperty
   a_on: assert property (p_on) else $error("hv not set");
   a_rcv: assert property (p_rcv) else $error("bad recovery");
   a_all: assert property (p_all) else $error("hv at all protect");
   a_rng: assert property (p_rng) else $error("hv in range");
   a_mass: assert property (p_mass) else $error("mass at protect");
   a_lock: assert property (p_lock) else $error("protect changed");
   a_abt: assert property (p_abt) else $error("no abort");
   a_sby: assert property (p_sby) else $error("active in standby");
   property p_rlen;
      $rose(array_read_ok_r) && $past(since_hv) != 8'h00 |->
         $past(since_hv) >= RCV_MIN;
   endproperty
   a_rlen: assert property (p_rlen) else $error("early read");
endmodule
bind fpp_ctrl fpp_ctrl_sva u_sva (.*);
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the flash program and protect controller.
// Assumes: 40 MHz clock and default widths.
// Notes: Recovery is awaited under a bounded count.
`timescale 1ns/1ps
`default_nettype none
module tb;
   reg sys_clk = 0, rst_n = 0, sel = 0, ers = 0, mas = 0, req = 0, bwr = 0;
   reg tv = 0, wm = 0, sm = 0;
   reg [15:0] addr = 0;
   reg [7:0] bwd = 0;
   wire prg, era, msr, hv, rok, sby, rfs, tvr;
   wire [7:0] bp;
   integer bad_count = 0, cmp_count = 0, i;
   always #12.5 sys_clk = ~sys_clk;
   fpp_ctrl u_fpp_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
      .program_select_bit(sel), .erase_select_bit(ers), .mass_erase_bit(mas),
      .high_voltage_enable_req(req), .target_addr(addr),
      .block_protect_wr(bwr), .block_protect_wdata(bwd),
      .elevated_test_voltage(tv), .wait_mode(wm), .stop_mode(sm),
      .array_program_r(prg), .array_erase_r(era), .array_mass_r(msr),
      .high_voltage_enable_r(hv), .array_read_ok_r(rok), .standby_r(sby),
      .hv_refused_r(rfs), .block_protect_reg_r(bp), .test_voltage_r(tvr));
   task end_of_test;
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task tick(input integer n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task op(input s, input e, input [15:0] a, input x, input [1:0] lp);
      @(posedge sys_clk);
      {sel, ers, mas, addr} <= {s, e, e, a};
      @(posedge sys_clk);
      req <= 1;
      tick(3);
      chk(hv, x);
      chk(rfs, !x);
      chk({prg, era, msr}, {s, e, e & x});
      @(posedge sys_clk);
      {sm, wm} <= lp;
      tick(5);
      if (lp != 0) chk({sby, hv}, 2'b10);
      if (lp != 0) chk({prg, era, msr}, 3'h0);
      @(posedge sys_clk);
      {sel, ers, mas, req, sm, wm} <= 6'h00;
      i = 0;
      while (rok !== 1'b1 && i < 80) begin
         tick(1);
         i = i + 1;
      end
      if (i == 80) begin
         bad_count = bad_count + 1;
         end_of_test;
      end
      chk(i > 30, x);
   endtask
   task bpw(input t, input [7:0] v, input [7:0] ex);
      @(posedge sys_clk);
      tv <= t;
      tick(4);
      chk(tvr, t);
      @(posedge sys_clk);
      {bwr, bwd} <= {1'b1, v};
      @(posedge sys_clk);
      {bwr, tv} <= 2'h0;
      tick(2);
      chk(bp, ex);
   endtask
   task prog_row;
      @(posedge sys_clk);
      {sel, addr} <= {1'b1, 16'hf000};
      tick(2);
      chk(bp, 8'hff);
      @(posedge sys_clk);
      req <= 1;
      for (i = 0; i < 2; i = i + 1) begin
         tick(1200);
         chk({prg, hv}, 2'b11);
         @(posedge sys_clk);
         addr <= addr + 16'h0001;
         tv <= ~tv;
      end
      @(posedge sys_clk);
      sel <= 0;
      tick(200);
      chk({prg, hv}, 2'b01);
      @(posedge sys_clk);
      req <= 0;
      i = 0;
      while (rok !== 1'b1 && i < 80) begin
         tick(1);
         i = i + 1;
      end
      if (i == 80) begin
         bad_count = bad_count + 1;
         end_of_test;
      end
      chk(i >= 40, 1);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1;
      tick(2);
      chk(bp, 8'hff);
      op(1, 0, 16'hffff, 1, 0);
      prog_row;
      op(1, 0, 16'h8000, 1, 1);
      op(1, 0, 16'h8000, 1, 2);
      op(0, 1, 16'h8000, 1, 0);
      bpw(0, 8'h80, 8'hff);
      bpw(1, 8'h80, 8'h80);
      op(1, 0, 16'h9fff, 1, 0);
      op(1, 0, 16'ha000, 0, 0);
      op(0, 1, 16'h1000, 0, 0);
      bpw(1, 8'h00, 8'h00);
      op(1, 0, 16'h0000, 0, 0);
      end_of_test;
   end
endmodule
`default_nettype wire
